// ===== hw/port_pin_defines.vh
`ifndef PORT_PIN_DEFINES_VH
`define PORT_PIN_DEFINES_VH

// register indices, byte address is four times the index
`define IDX_EDGE_SEL_HIGH      8'hE8
`define IDX_EDGE_SEL_LOW       8'hE9
`define IDX_PENDING            8'hEA
`define IDX_FUNC_HIGH          8'hEB
`define IDX_FUNC_MIDDLE        8'hEC
`define IDX_FUNC_LOW           8'hED
`define IDX_EVENT_STATUS       8'hF0
`define IDX_EVENT_MASK         8'hF1
`define IDX_PORT3_OUT_DATA     8'hF2
`define IDX_PORT3_PIN_LEVEL    8'hF3

// reset values
`define RST_BYTE               8'h00

// edge-select codes
`define EDGE_OFF               2'h0
`define EDGE_FALL              2'h1
`define EDGE_RISE              2'h2
`define EDGE_BOTH              2'h3

// normalised pin functions
`define FN_INPUT               3'h0
`define FN_PATTERN             3'h1
`define FN_LCD                 3'h2
`define FN_OUTPUT              3'h3
`define FN_ALT                 3'h4

// edges after reset before port 2 edge detection is trusted
`define SYNC_FILL_DONE         2'h3

// ahb transfer type bit that marks an active transfer
`define HTRANS_ACTIVE_BIT      1

`endif

// ===== hw/port_pin_config_ext_irq.v
// The implementer's own choice: register access over AHB-Lite.
`include "port_pin_defines.vh"

// Function
// RULE1 - lines two..zero edge select at bits 5:4, 3:2, 1:0; 00 disables
// RULE2 - code 01 requests on a falling edge of the port 2 pin only
// RULE3 - code 10 requests on a rising edge of the port 2 pin only
// RULE4 - code 11 requests on both falling and rising edges
// RULE5 - pending register bit n for line n; reads 1 pending; write 0 clears
// RULE6 - pin 7 by high bits 7:5: input, pattern7, lcd, output, buzzer
// RULE7 - pin 6 by high bits 4:3: input with timer d1 clock, pattern, lcd, out
// RULE8 - pin 5 by high bits 2:0: input capture d1, pattern, lcd, out, d1 out
// RULE9 - pin 4 by middle bits 7:6: input with timer d0 clock, pattern, lcd, out
// RULE10 - pin 3 by middle 5:3: input capture d0, pattern, lcd, out, d0 out
// RULE11 - pin 2 by middle 2:0: input, pattern, lcd, output, unnamed alternate
// RULE12 - low register bits 7:6 unused, no effect on pins
// RULE13 - pin 1 by low bits 5:3: input, pattern, lcd, output, timer c out
// RULE14 - pin 0 by low bits 2:0: input, pattern, lcd, output, timer b pwm
// RULE15 - lines seven..four use same coding in high register, 7:6 down to 1:0
// RULE16 - port 2 pins synchronised; pending set on the detected edge cycle
// RULE17 - reset clears pending and port 3 fields, all pins inputs
module port_pin_config_ext_irq (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_n_i,
  // ahb-lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // port 2 pins
  input  wire [7:0]  port2_pin_i,
  // port 3 pins
  input  wire [7:0]  port3_pin_i,
  output wire [7:0]  port3_pin_o,
  output wire [7:0]  port3_pin_oe_o,
  // peripheral sources for port 3
  input  wire [7:0]  pattern_generator_i,
  input  wire [7:0]  lcd_segment_i,
  input  wire        buzzer_output_i,
  input  wire        timer_d1_output_i,
  input  wire        timer_d0_output_i,
  input  wire        timer_c_output_i,
  input  wire        timer_b_pwm_output_i,
  input  wire        pin2_alternate_i,
  // timer inputs taken from port 3
  output wire        timer_d1_clock_input_o,
  output wire        timer_d1_capture_input_o,
  output wire        timer_d0_clock_input_o,
  output wire        timer_d0_capture_input_o,
  // pending flags and interrupt
  output wire [7:0]  ext_irq_pending_o,
  output wire        irq_o
);

  reg  [7:0]  edge_sel_high;
  reg  [7:0]  edge_sel_low;
  reg  [7:0]  pending;
  reg  [7:0]  func_high;
  reg  [7:0]  func_middle;
  reg  [7:0]  func_low;
  reg  [7:0]  event_status;
  reg  [7:0]  event_mask;
  reg  [7:0]  out_data;
  reg  [7:0]  p2_meta;
  reg  [7:0]  p2_sync;
  reg  [7:0]  p2_prev;
  reg  [7:0]  p3_meta;
  reg  [7:0]  p3_sync;
  reg  [7:0]  pin_out;
  reg  [7:0]  pin_oe;
  reg  [3:0]  timer_in;
  reg  [31:0] rdata;
  reg         wr_pend;
  reg  [7:0]  wr_idx;
  reg  [7:0]  edge_hit;
  reg  [7:0]  next_pin_out;
  reg  [7:0]  next_pin_oe;
  reg  [2:0]  fn;
  reg  [1:0]  code;
  reg  [7:0]  rd_byte;
  reg  [7:0]  next_pending;
  reg  [7:0]  next_status;
  wire [15:0] edge_sel;
  wire [7:0]  rise;
  wire [7:0]  fall;
  wire        addr_ok;
  wire        take;
  wire [7:0]  a_idx;
  wire        rd_take;
  wire [7:0]  wbyte;
  integer     i;
  integer     ln;
  reg  [1:0]  sync_fill;
  wire        sync_ready;
  wire        pin6_input;
  wire        pin5_input;
  wire        pin4_input;
  wire        pin3_input;

  // one normalised code lets a single decode serve 2- and 3-bit fields
  // 3-bit field: 1xx is the alternate function
  function [2:0] fn3;
    input [2:0] f;
    begin
      fn3 = f[2] ? `FN_ALT : f;
    end
  endfunction

  // 2-bit field: no alternate, 11 is output
  function [2:0] fn2;
    input [1:0] f;
    begin
      fn2 = {1'b0, f};
    end
  endfunction

  // hsize not decoded: every access is taken as a whole word
  // address bits above the map must be zero, so aliases read zero
  // ahb address phase decode, only whole-word aligned registers
  assign addr_ok = (haddr_i[31:10] == 22'h0) && (haddr_i[1:0] == 2'h0);
  assign take    = hsel_i && hready_i && htrans_i[`HTRANS_ACTIVE_BIT];
  assign a_idx   = haddr_i[9:2];
  assign rd_take = take && !hwrite_i && addr_ok;
  assign wbyte   = hwdata_i[7:0];

  // no error response needed: unmapped words read zero
  // zero wait state slave, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata;

  // lines 7..4 from the high register, 3..0 from the low one
  // all eight edge fields as one vector, line n at bits 2n+1:2n
  assign edge_sel = {edge_sel_high, edge_sel_low}; // [RULE1] [RULE15]

  // warm-up count: meta, sync and prev hold real pin samples only from
  // the third edge after reset; until then prev shows its reset zero and
  // a pin idling high through reset would look like a rising edge
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync_fill <= 2'h0;
    end else if (sync_fill != `SYNC_FILL_DONE) begin
      sync_fill <= sync_fill + 2'h1;
    end
  end
  assign sync_ready = (sync_fill == `SYNC_FILL_DONE); // [RULE16]

  // edges seen on the synchronised pins only, masked during warm-up
  assign rise = p2_sync & ~p2_prev & {8{sync_ready}};
  assign fall = ~p2_sync & p2_prev & {8{sync_ready}};

  // edge qualification per line
  always @* begin
    edge_hit = 8'h00;
    // a disabled line ignores both edges; a flag already set stays set
    for (ln = 0; ln < 8; ln = ln + 1) begin
      code = edge_sel[2*ln +: 2];
      case (code)
        `EDGE_OFF:  edge_hit[ln] = 1'b0;     // [RULE1]
        `EDGE_FALL: edge_hit[ln] = fall[ln]; // [RULE2]
        `EDGE_RISE: edge_hit[ln] = rise[ln]; // [RULE3]
        `EDGE_BOTH: edge_hit[ln] = rise[ln] | fall[ln]; // [RULE4]
        default:    edge_hit[ln] = 1'b0;
      endcase
    end
  end

  // pending: write 0 clears, a new edge wins over the clear;
  // losing a request is worse than honouring a racing clear
  always @* begin
    next_pending = pending;
    if (wr_pend && (wr_idx == `IDX_PENDING)) begin
      next_pending = pending & wbyte; // [RULE5]
    end
    next_pending = next_pending | edge_hit; // [RULE5] [RULE16]
  end

  // event status: cleared by its read, set wins over the clear
  // clear taken in the address phase, the read data shows the old bits
  always @* begin
    next_status = event_status;
    if (rd_take && (a_idx == `IDX_EVENT_STATUS)) begin
      next_status = 8'h00;
    end
    next_status = next_status | edge_hit;
  end

  // register map by word index, byte address four times the index:
  //   E8 edge select, lines 7..4
  //   E9 edge select, lines 3..0
  //   EA pending flags, write 0 clears
  //   EB, EC, ED function select, pins 7..5, 4..2, 1..0
  //   F0 event status, a read clears it
  //   F1 event mask, 1 lets a status bit reach irq
  //   F2 output-mode data, F3 synchronised port 3 levels
  // anything else reads zero and ignores writes
  // read mux for the address phase
  always @* begin
    case (a_idx)
      `IDX_EDGE_SEL_HIGH:   rd_byte = edge_sel_high;
      `IDX_EDGE_SEL_LOW:    rd_byte = edge_sel_low;
      `IDX_PENDING:         rd_byte = pending; // [RULE5]
      `IDX_FUNC_HIGH:       rd_byte = func_high;
      `IDX_FUNC_MIDDLE:     rd_byte = func_middle;
      `IDX_FUNC_LOW:        rd_byte = func_low;
      `IDX_EVENT_STATUS:    rd_byte = event_status;
      `IDX_EVENT_MASK:      rd_byte = event_mask;
      `IDX_PORT3_OUT_DATA:  rd_byte = out_data;
      `IDX_PORT3_PIN_LEVEL: rd_byte = p3_sync;
      default:              rd_byte = 8'h00;
    endcase
  end

  // write intent remembered from the address phase; the write lands at
  // the end of its data phase, so a read straight after it sees the old
  // value of that register
  // ahb data phase bookkeeping and read data
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
      rdata   <= 32'h00000000;
    end else begin
      if (hready_i) begin
        wr_pend <= take && hwrite_i && addr_ok;
        wr_idx  <= a_idx;
      end
      if (rd_take) begin
        rdata <= {24'h000000, rd_byte};
      end else if (take) begin
        // unmapped or write: data bus reads zero
        rdata <= 32'h00000000;
      end
    end
  end

  // pending and status live in the flag process, one driver each
  // configuration registers written in the data phase
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      edge_sel_high <= `RST_BYTE;
      edge_sel_low  <= `RST_BYTE;
      func_high     <= `RST_BYTE; // [RULE17]
      func_middle   <= `RST_BYTE; // [RULE17]
      func_low      <= `RST_BYTE; // [RULE17]
      event_mask    <= `RST_BYTE;
      out_data      <= `RST_BYTE;
    end else if (wr_pend) begin
      case (wr_idx)
        `IDX_EDGE_SEL_HIGH:  edge_sel_high <= wbyte; // [RULE15]
        `IDX_EDGE_SEL_LOW:   edge_sel_low  <= wbyte; // [RULE1]
        `IDX_FUNC_HIGH:      func_high     <= wbyte;
        `IDX_FUNC_MIDDLE:    func_middle   <= wbyte;
        // bits 7:6 held for readback, never decoded
        `IDX_FUNC_LOW:       func_low      <= wbyte; // [RULE12]
        `IDX_EVENT_MASK:     event_mask    <= wbyte;
        `IDX_PORT3_OUT_DATA: out_data      <= wbyte;
        default:             out_data      <= out_data;
      endcase
    end
  end

  // port 3 levels pass two flops before the read mux sees them, and a third before a timer does
  // flags and pin synchronisers
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pending      <= `RST_BYTE; // [RULE17]
      event_status <= `RST_BYTE;
      p2_meta      <= 8'h00;
      p2_sync      <= 8'h00;
      p2_prev      <= 8'h00;
      p3_meta      <= 8'h00;
      p3_sync      <= 8'h00;
    end else begin
      pending      <= next_pending;
      event_status <= next_status;
      p2_meta      <= port2_pin_i; // [RULE16]
      p2_sync      <= p2_meta;
      // prev trails sync by one edge; warm-up count hides its reset zero
      p2_prev      <= p2_sync;
      p3_meta      <= port3_pin_i;
      p3_sync      <= p3_meta;
    end
  end

  // port 3 pin function decode
  always @* begin
    next_pin_out = 8'h00;
    next_pin_oe  = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      case (i)
        7: fn = fn3(func_high[7:5]);   // [RULE6]
        6: fn = fn2(func_high[4:3]);   // [RULE7]
        5: fn = fn3(func_high[2:0]);   // [RULE8]
        4: fn = fn2(func_middle[7:6]); // [RULE9]
        3: fn = fn3(func_middle[5:3]); // [RULE10]
        2: fn = fn3(func_middle[2:0]); // [RULE11]
        1: fn = fn3(func_low[5:3]);    // [RULE13]
        default: fn = fn3(func_low[2:0]); // [RULE14]
      endcase
      // one decode for all pins, fed by the normalised code
      case (fn)
        `FN_PATTERN: begin
          next_pin_out[i] = pattern_generator_i[i];
          next_pin_oe[i]  = 1'b1;
        end
        `FN_LCD: begin
          next_pin_out[i] = lcd_segment_i[i];
          next_pin_oe[i]  = 1'b1;
        end
        `FN_OUTPUT: begin
          next_pin_out[i] = out_data[i];
          next_pin_oe[i]  = 1'b1;
        end
        `FN_ALT: begin
          next_pin_oe[i] = 1'b1;
          case (i)
            7: next_pin_out[i] = buzzer_output_i;      // [RULE6]
            5: next_pin_out[i] = timer_d1_output_i;    // [RULE8]
            3: next_pin_out[i] = timer_d0_output_i;    // [RULE10]
            2: next_pin_out[i] = pin2_alternate_i;     // [RULE11]
            1: next_pin_out[i] = timer_c_output_i;     // [RULE13]
            // pins 6 and 4 have 2-bit fields and never reach this branch
            default: next_pin_out[i] = timer_b_pwm_output_i; // [RULE14]
          endcase
        end
        default: begin
          // input mode: pin released
          next_pin_out[i] = 1'b0;
          next_pin_oe[i]  = 1'b0;
        end
      endcase
    end
  end

  // a timer input follows its pin only while the pin is in input mode
  assign pin6_input = (func_high[4:3] == 2'h0);   // [RULE7]
  assign pin5_input = (func_high[2:0] == 3'h0);   // [RULE8]
  assign pin4_input = (func_middle[7:6] == 2'h0); // [RULE9]
  assign pin3_input = (func_middle[5:3] == 3'h0); // [RULE10]

  // the flop costs a cycle of latency but keeps pins free of glitches
  // registered pin drive and timer inputs, one cycle of latency
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_out  <= 8'h00;
      pin_oe   <= 8'h00; // [RULE17]
      timer_in <= 4'h0;
    end else begin
      pin_out  <= next_pin_out;
      pin_oe   <= next_pin_oe;
      // timer sees the pin only while it is an input, else low
      // same field test as the pin decode, so oe and timer agree
      timer_in[3] <= p3_sync[6] & pin6_input; // [RULE7]
      timer_in[2] <= p3_sync[5] & pin5_input; // [RULE8]
      timer_in[1] <= p3_sync[4] & pin4_input; // [RULE9]
      timer_in[0] <= p3_sync[3] & pin3_input; // [RULE10]
    end
  end

  // irq from registered status and mask, a level free of glitches
  // outputs
  assign port3_pin_o              = pin_out;
  assign port3_pin_oe_o           = pin_oe;
  assign timer_d1_clock_input_o   = timer_in[3];
  assign timer_d1_capture_input_o = timer_in[2];
  assign timer_d0_clock_input_o   = timer_in[1];
  assign timer_d0_capture_input_o = timer_in[0];
  assign ext_irq_pending_o        = pending;
  assign irq_o                    = |(event_status & event_mask);

endmodule // port_pin_config_ext_irq

// ===== testbench/port_pin_config_ext_irq_props.sv
module port_pin_props (
  // clock and reset
  input logic        clk_i,
  input logic        reset_n_i,
  // bus side
  input logic        hsel_i,
  input logic [31:0] haddr_i,
  input logic [1:0]  htrans_i,
  input logic        hwrite_i,
  input logic        hready_i,
  input logic [31:0] hwdata_i,
  input logic [31:0] hrdata_o,
  input logic        hreadyout_o,
  input logic        hresp_o,
  // pin side
  input logic [7:0]  port2_pin_i,
  input logic [7:0]  port3_pin_oe_o,
  input logic        timer_d1_clock_input_o,
  input logic        timer_d0_capture_input_o,
  input logic [7:0]  ext_irq_pending_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // accepted address phase, pending sits at byte address 4 * EA
  wire take = hsel_i & hready_i & htrans_i[1];
  wire pend_adr = haddr_i == 32'h000003A8;
  sequence s_pend_rd;
    take && !hwrite_i && pend_adr;
  endsequence
  reset_clear_a: assert property ($rose(reset_n_i) |->
    ext_irq_pending_o == 8'h00 && port3_pin_oe_o == 8'h00)
    else $error("state not cleared by reset");
  ready_always_a: assert property (hreadyout_o)
    else $error("slave inserted a wait state");
  resp_okay_a: assert property (!hresp_o)
    else $error("slave answered with an error");
  pend_read_a: assert property (s_pend_rd |=>
    hrdata_o[7:0] == $past(ext_irq_pending_o))
    else $error("pending read data wrong");
  unmapped_zero_a: assert property (take && !hwrite_i &&
    haddr_i[31:10] != 22'h0 |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  // a flag only drops through a data phase that wrote 0 to it
  pend_fall_a: assert property ($past(reset_n_i) &&
    |($past(ext_irq_pending_o) & ~ext_irq_pending_o) |->
    $past(take && hwrite_i && pend_adr, 2) && ($past(ext_irq_pending_o)
    & ~ext_irq_pending_o & $past(hwdata_i[7:0])) == 8'h00)
    else $error("pending flag cleared without a write");
  // a flag only rises three edges after its pin changed
  pend_rise_a: assert property ($past(reset_n_i) &&
    |(ext_irq_pending_o & ~$past(ext_irq_pending_o)) |->
    (ext_irq_pending_o & ~$past(ext_irq_pending_o) &
    ~($past(port2_pin_i, 3) ^ $past(port2_pin_i, 4))) == 8'h00)
    else $error("pending flag set without a pin edge");
  clock_gate_a: assert property (timer_d1_clock_input_o |->
    !port3_pin_oe_o[6])
    else $error("timer clock fed while pin six drives");
  capture_gate_a: assert property (timer_d0_capture_input_o |->
    !port3_pin_oe_o[3])
    else $error("timer capture fed while pin three drives");
endmodule // port_pin_props

bind port_pin_config_ext_irq port_pin_props props (.clk_i, .reset_n_i,
  .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .port2_pin_i, .port3_pin_oe_o,
  .timer_d1_clock_input_o, .timer_d0_capture_input_o, .ext_irq_pending_o);

// ===== testbench/pin_world.sv
module pin_world #(
  parameter logic [7:0] PAT = 8'hA5,
  parameter logic [7:0] LCD = 8'h5A,
  parameter logic [7:0] ALT = 8'h0A
) (
  // device pins and the outside level
  input  logic [7:0] port3_pin_o,
  input  logic [7:0] port3_pin_oe_o,
  input  logic [7:0] drive_i,
  output logic [7:0] port3_pin_i,
  // peripheral sources
  output logic [7:0] pattern_o,
  output logic [7:0] lcd_o,
  output logic [7:0] alt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin shows the device value, a released one the outside level
  assign port3_pin_i = (port3_pin_oe_o & port3_pin_o) |
                       (~port3_pin_oe_o & drive_i);
  // sources hold still so every mode is predictable, pattern and lcd differ
  assign pattern_o = PAT;
  assign lcd_o = LCD;
  assign alt_o = ALT;
endmodule // pin_world

// ===== testbench/port_pin_config_ext_irq_test.sv
`include "port_pin_defines.vh"
module port_pin_config_ext_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PAT = 8'hA5, LCD = 8'h5A, ALT = 8'h0A;
  localparam logic [7:0] OUTD = 8'h3C, EXT = 8'h78;
  logic        clk_i = 0, reset_n_i = 0, hwrite_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, rdv;
  logic [1:0]  htrans_i = 0;
  logic [7:0]  port2_pin_i = 0;
  wire  [31:0] hrdata_o;
  wire         hreadyout_o, hresp_o, irq_o, d1clk, d1cap, d0clk, d0cap;
  wire  [7:0]  p3_in, p3_o, p3_oe, pat, lcd, alt, pend;
  int          fails = 0, comparisons = 0, cyc = 0;

  port_pin_config_ext_irq dut (.clk_i, .reset_n_i, .hsel_i(1'b1), .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .port2_pin_i, .port3_pin_i(p3_in),
    .port3_pin_o(p3_o), .port3_pin_oe_o(p3_oe), .pattern_generator_i(pat),
    .lcd_segment_i(lcd), .buzzer_output_i(alt[7]),
    .timer_d1_output_i(alt[5]), .timer_d0_output_i(alt[3]),
    .pin2_alternate_i(alt[2]), .timer_c_output_i(alt[1]),
    .timer_b_pwm_output_i(alt[0]), .timer_d1_clock_input_o(d1clk),
    .timer_d1_capture_input_o(d1cap), .timer_d0_clock_input_o(d0clk),
    .timer_d0_capture_input_o(d0cap), .ext_irq_pending_o(pend), .irq_o);
  pin_world #(.PAT(PAT), .LCD(LCD), .ALT(ALT)) world (.port3_pin_o(p3_o),
    .port3_pin_oe_o(p3_oe), .drive_i(EXT), .port3_pin_i(p3_in),
    .pattern_o(pat), .lcd_o(lcd), .alt_o(alt));

  initial forever #5 clk_i = ~clk_i;
  // hang guard, the whole run needs under six hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic ahb(input logic w, input logic [31:0] a, d);
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rdv = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    ahb(1'b1, {22'h0, i, 2'h0}, d);
  endtask
  task automatic rd(input logic [7:0] i);
    ahb(1'b0, {22'h0, i, 2'h0}, 32'h0);
  endtask
  // one line, one code: rising then falling edge, each one checked and then cleared
  task automatic edge_case(input int l, input logic [1:0] c);
    logic [7:0] b;
    b = 8'h01 << l;
    wr(l > 3 ? `IDX_EDGE_SEL_HIGH : `IDX_EDGE_SEL_LOW,
       {30'h0, c} << (2 * (l % 4)));
    wr(`IDX_EVENT_MASK, c == `EDGE_RISE ? 8'h00 : b);
    for (int d = 1; d >= 0; d--) begin
      port2_pin_i[l] <= d[0];
      repeat (4) @(posedge clk_i);
      #1;
      check("pending", pend, c[d] ? b : 8'h00);
      check("irq", irq_o, c[d] && c != `EDGE_RISE);
      @(posedge clk_i);
      rd(`IDX_EVENT_STATUS);
      check("status", rdv, c[d] ? b : 8'h00);
      wr(`IDX_PENDING, ~b);
      #1;
      check("cleared", {pend, irq_o}, 9'h0);
      @(posedge clk_i);
    end
  endtask
  // every pin set to one function code, 2-bit fields see only the low bits
  task automatic func_case(input int c);
    logic [7:0] eo, ev;
    int k;
    wr(`IDX_FUNC_HIGH, {c[2:0], c[1:0], c[2:0]});
    wr(`IDX_FUNC_MIDDLE, {c[1:0], c[2:0], c[2:0]});
    wr(`IDX_FUNC_LOW, {2'h3, c[2:0], c[2:0]});
    wr(`IDX_PORT3_OUT_DATA, OUTD);
    repeat (4) @(posedge clk_i);
    #1;
    for (int n = 0; n < 8; n++) begin
      k = (n == 6 || n == 4) ? c % 4 : (c > 3 ? 4 : c);
      ev[n] = k != 0;
      eo[n] = k == 1 ? PAT[n] : k == 2 ? LCD[n] : k == 3 ? OUTD[n] :
              k == 0 ? 1'b0 : ALT[n];
    end
    check("drive", p3_oe, ev);
    check("value", p3_o & ev, eo);
    check("timer", {d1clk, d1cap, d0clk, d0cap}, 4'(~ev[6:3]));
    @(posedge clk_i);
    rd(`IDX_FUNC_LOW);
    check("low", rdv, {2'h3, c[2:0], c[2:0]});
    rd(`IDX_FUNC_MIDDLE);
    check("middle", rdv, {c[1:0], c[2:0], c[2:0]});
    rd(`IDX_PORT3_PIN_LEVEL);
    check("level", rdv, eo | (EXT & ~ev));
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    check("oe reset", p3_oe, 8'h00);
    for (int i = 'hE8; i <= 'hED; i++) begin
      rd(8'(i));
      check("reset", rdv, 32'h0);
    end
    // unmapped place: write lost, read zero
    ahb(1'b1, 32'h00000400, 32'hFF);
    ahb(1'b0, 32'h00000400, 32'h0);
    check("unmapped", rdv, 32'h0);
    for (int l = 0; l < 8; l += (l == 2) ? 5 : 1)
      for (int c = 0; c < 4; c++)
        edge_case(l, c);
    for (int c = 0; c < 8; c++)
      func_case(c);
    // reset again with port 2 high, then arm rising edges at once
    port2_pin_i <= 8'hFF;
    reset_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wr(`IDX_EDGE_SEL_LOW, 32'hAA);
    repeat (4) @(posedge clk_i);
    #1;
    check("no false edge", pend, 8'h00);
    final_report();
  end
endmodule // port_pin_config_ext_irq_test
